// ---- common/tape_pkg.sv ----
// Shared constants for the tape host handshake block
package tape_pkg;
  localparam int DATA_W = 8;
  // Command codes presented on the bus
  localparam logic [7:0] CMD_READ_STATUS = 8'hc0;
  // Hold time of the interface reset pulse
  localparam int RESET_PULSE_NS = 25000;
  localparam int CLK_PERIOD_NS = 50;
  localparam int RESET_PULSE_CYC =
    (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Count width for the reset pulse timer
  localparam int RST_CNT_W = 10;
  // Operation kinds requested by the user side
  localparam logic [1:0] OP_CMD = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
endpackage

// ---- design/sync2.sv ----
// Two-stage synchroniser for a bundle of pin inputs
`timescale 1ns/10ps
`default_nettype none
module sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Pins in, synchronised out
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_sync_out;

  always_comb begin
    next_meta = async_in;
    next_sync_out = meta;
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      meta <= '0;
      sync_out <= '0;
    end else begin
      meta <= next_meta;
      sync_out <= next_sync_out;
    end
  end
endmodule
`default_nettype wire

// ---- design/tape_host_handshake.sv ----
// Host-side handshake controller for a cartridge tape parallel port
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - On exception the host issues read status before anything else.
// - Direction signal enables or disables host data bus transceivers.
// - Host deasserts on-line at start of every read or write operation.
// - Host asserts request while a valid command byte is on the bus.
// - Each data item pairs host transfer with drive acknowledge.
module tape_host_handshake #(
  parameter int DATA_W = tape_pkg::DATA_W,
  parameter int RESET_CYC = tape_pkg::RESET_PULSE_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // User side: operation request
  input wire logic op_valid,
  input wire logic [1:0] op_kind,
  input wire logic [DATA_W-1:0] op_cmd,
  output logic op_ready,
  // User side: write data stream
  input wire logic wr_valid,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic wr_last,
  output logic wr_ready,
  // User side: read data stream
  output logic rd_valid,
  output logic [DATA_W-1:0] rd_data,
  input wire logic rd_stop,
  // User side: status and reset
  input wire logic drive_reset_req,
  output logic status_valid,
  output logic [DATA_W-1:0] status_data,
  output logic busy,
  // Drive pins
  input wire logic [DATA_W-1:0] bus_in,
  output logic [DATA_W-1:0] bus_out,
  output logic bus_oe,
  input wire logic tape_ready,
  input wire logic tape_exception,
  input wire logic tape_ack,
  input wire logic tape_dir,
  output logic tape_request,
  output logic tape_xfer,
  output logic tape_online,
  output logic tape_reset
);
  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_RST = 4'h1,
    S_CMD_RDY = 4'h2,
    S_CMD_REQ = 4'h3,
    S_CMD_END = 4'h4,
    S_DAT_RDY = 4'h5,
    S_DAT_XFER = 4'h6,
    S_DAT_REL = 4'h7,
    S_STAT_RDY = 4'h8,
    S_STAT_XFER = 4'h9,
    S_STAT_REL = 4'ha
  } state_t;

  logic [DATA_W-1:0] bus_s;
  logic rdy_s, exp_s, ack_s, dir_s;
  sync2 #(.W(DATA_W + 4)) u_sync (
    .mclk(mclk),
    .rstn(rstn),
    .async_in({bus_in, tape_ready, tape_exception, tape_ack, tape_dir}),
    .sync_out({bus_s, rdy_s, exp_s, ack_s, dir_s})
  );

  state_t state, next_state;
  logic [1:0] kind, next_kind;
  logic [DATA_W-1:0] next_bus_out, next_rd_data, next_status_data;
  logic next_bus_oe, next_request, next_xfer, next_online, next_reset;
  logic next_op_ready, next_wr_ready, next_rd_valid, next_status_valid;
  logic next_busy, last, next_last;
  logic [tape_pkg::RST_CNT_W-1:0] cnt, next_cnt;

  always_comb begin
    next_state = state;
    next_kind = kind;
    next_bus_out = bus_out;
    next_bus_oe = bus_oe;
    next_request = tape_request;
    next_xfer = tape_xfer;
    next_online = tape_online;
    next_reset = 1'b0;
    next_rd_data = rd_data;
    next_status_data = status_data;
    next_last = last;
    next_cnt = cnt;
    next_op_ready = 1'b0;
    next_wr_ready = 1'b0;
    next_rd_valid = 1'b0;
    next_status_valid = 1'b0;
    next_busy = 1'b1;
    case (state)
      S_IDLE: begin
        next_busy = 1'b0;
        next_bus_oe = 1'b0;
        if (exp_s) begin
          next_kind = tape_pkg::OP_CMD;
          next_bus_out = tape_pkg::CMD_READ_STATUS;
          next_state = S_CMD_RDY;
          next_busy = 1'b1;
        end else if (drive_reset_req) begin
          next_cnt = tape_pkg::RST_CNT_W'(RESET_CYC);
          next_reset = 1'b1;
          next_state = S_RST;
          next_busy = 1'b1;
        end else if (op_valid) begin
          next_op_ready = 1'b1;
          next_kind = op_kind;
          next_bus_out = op_cmd;
          next_busy = 1'b1;
          if (op_kind != tape_pkg::OP_CMD) begin
            next_online = 1'b0;
          end else begin
            next_online = 1'b1;
          end
          next_state = S_CMD_RDY;
        end
      end
      S_RST: begin
        next_reset = 1'b1;
        next_cnt = cnt - 1'b1;
        if (cnt <= 1) begin
          next_reset = 1'b0;
          next_state = S_IDLE;
        end
      end
      S_CMD_RDY: begin
        if (rdy_s) begin
          next_bus_oe = 1'b1;
          next_request = 1'b1;
          next_state = S_CMD_REQ;
        end
      end
      S_CMD_REQ: begin
        if (!rdy_s) begin
          next_request = 1'b0;
          next_state = S_CMD_END;
        end
      end
      S_CMD_END: begin
        next_bus_oe = 1'b0;
        next_last = 1'b0;
        // Status byte follows its command
        // Exception drops once the drive sees the command, so not tested
        if (kind == tape_pkg::OP_CMD &&
            bus_out == tape_pkg::CMD_READ_STATUS) begin
          next_state = S_STAT_RDY;
        end else if (kind == tape_pkg::OP_CMD) begin
          next_state = S_IDLE;
        end else begin
          next_state = S_DAT_RDY;
        end
      end
      S_DAT_RDY: begin
        next_bus_oe = !dir_s && kind == tape_pkg::OP_WRITE;
        if (exp_s || last) begin
          next_state = S_IDLE;
        end else if (rdy_s && kind == tape_pkg::OP_WRITE) begin
          next_wr_ready = 1'b1;
          if (wr_valid) begin
            next_bus_out = wr_data;
            next_last = wr_last;
            next_xfer = 1'b1;
            next_state = S_DAT_XFER;
          end
        end else if (rdy_s && (!rd_stop)) begin
          next_xfer = 1'b1;
          next_state = S_DAT_XFER;
        end else if (rd_stop) begin
          next_state = S_IDLE;
        end
      end
      S_DAT_XFER: begin
        if (ack_s) begin
          if (kind == tape_pkg::OP_READ) begin
            next_rd_data = bus_s;
            next_rd_valid = 1'b1;
          end
          next_xfer = 1'b0;
          next_state = S_DAT_REL;
        end
      end
      S_DAT_REL: begin
        if (!ack_s) begin
          next_state = S_DAT_RDY;
        end
      end
      S_STAT_RDY: begin
        next_bus_oe = 1'b0;
        if (rdy_s) begin
          next_xfer = 1'b1;
          next_state = S_STAT_XFER;
        end
      end
      S_STAT_XFER: begin
        if (ack_s) begin
          next_status_data = bus_s;
          next_status_valid = 1'b1;
          next_xfer = 1'b0;
          next_state = S_STAT_REL;
        end
      end
      S_STAT_REL: begin
        if (!ack_s) begin
          next_online = 1'b1;
          next_state = S_IDLE;
        end
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state <= S_IDLE;
      kind <= tape_pkg::OP_CMD;
      bus_out <= '0;
      bus_oe <= 1'b0;
      tape_request <= 1'b0;
      tape_xfer <= 1'b0;
      tape_online <= 1'b1;
      tape_reset <= 1'b0;
      rd_data <= '0;
      status_data <= '0;
      last <= 1'b0;
      cnt <= '0;
      op_ready <= 1'b0;
      wr_ready <= 1'b0;
      rd_valid <= 1'b0;
      status_valid <= 1'b0;
      busy <= 1'b0;
    end else begin
      state <= next_state;
      kind <= next_kind;
      bus_out <= next_bus_out;
      bus_oe <= next_bus_oe;
      tape_request <= next_request;
      tape_xfer <= next_xfer;
      tape_online <= next_online;
      tape_reset <= next_reset;
      rd_data <= next_rd_data;
      status_data <= next_status_data;
      last <= next_last;
      cnt <= next_cnt;
      op_ready <= next_op_ready;
      wr_ready <= next_wr_ready;
      rd_valid <= next_rd_valid;
      status_valid <= next_status_valid;
      busy <= next_busy;
    end
  end
endmodule
`default_nettype wire

// ---- test/tape_drive_model.sv ----
// Behavioural cartridge drive on the far side of the host port
`timescale 1ns/10ps
`default_nettype none
module tape_drive_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Host pins
  input wire logic [7:0] bus_out,
  input wire logic tape_request,
  input wire logic tape_xfer,
  input wire logic tape_reset,
  output logic [7:0] bus_in,
  output logic tape_ready,
  output logic tape_exception,
  output logic tape_ack,
  output logic tape_dir,
  // Bench control and capture
  input wire logic rd_mode,
  input wire logic exc_go,
  output logic [7:0] cmd,
  output logic [7:0] wbyte,
  output logic [7:0] n_wr
);
  logic stat;
  logic [7:0] rbyte;
  always @(posedge mclk) begin
    if (!rstn || tape_reset) begin
      {tape_ready, tape_exception, tape_ack, tape_dir, stat} <= '0;
      bus_in <= 8'h00;
      {cmd, wbyte, n_wr} <= '0;
      rbyte <= 8'h10;
    end else begin
      // Released bus toggles so stale data never matches
      bus_in <= tape_dir ? (stat ? 8'h5a : rbyte) : ~bus_in;
      tape_ready <= !tape_request && !tape_xfer && !tape_ack;
      tape_ack <= tape_xfer;
      if (tape_xfer && tape_ack && !tape_dir)
        wbyte <= bus_out;
      if (!tape_xfer && tape_ack && !tape_dir)
        n_wr <= n_wr + 8'h01;
      if (!tape_xfer && tape_ack && tape_dir && !stat)
        rbyte <= rbyte + 8'h01;
      if (!tape_xfer && tape_ack)
        stat <= 1'b0;
      if (tape_request)
        cmd <= bus_out;
      if (exc_go)
        tape_exception <= 1'b1;
      if (tape_request && bus_out == tape_pkg::CMD_READ_STATUS) begin
        tape_exception <= 1'b0;
        stat <= 1'b1;
      end
      tape_dir <= (rd_mode || stat) && !tape_request;
    end
  end
endmodule
`default_nettype wire

// ---- test/tape_host_handshake_monitor.sv ----
// Port checker for the tape host handshake
`timescale 1ns/10ps
`default_nettype none
module tape_host_handshake_monitor (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Watched ports
  input wire logic busy,
  input wire logic bus_oe,
  input wire logic [7:0] bus_out,
  input wire logic tape_ready,
  input wire logic tape_ack,
  input wire logic tape_dir,
  input wire logic tape_exception,
  input wire logic tape_request,
  input wire logic tape_xfer,
  input wire logic tape_online,
  input wire logic wr_ready,
  input wire logic rd_valid,
  input wire logic status_valid
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  property p_rq; tape_request |-> bus_oe; endproperty
  a_rq: assert property (p_rq) else $error("request undriven");
  property p_rqf; $fell(tape_request) |-> !tape_ready; endproperty
  a_rqf: assert property (p_rqf) else $error("request early");
  property p_dir; tape_xfer && tape_dir |-> !bus_oe; endproperty
  a_dir: assert property (p_dir) else $error("bus clash");
  property p_xr; $rose(tape_xfer) |-> !tape_ack && !$past(tape_ack); endproperty
  a_xr: assert property (p_xr) else $error("xfer over ack");
  property p_xf; $fell(tape_xfer) |-> tape_ack; endproperty
  a_xf: assert property (p_xf) else $error("xfer unacked");
  property p_ak; tape_ack |-> ##[1:12] !tape_xfer; endproperty
  a_ak: assert property (p_ak) else $error("xfer stuck");
  property p_ol; wr_ready || rd_valid |-> !tape_online; endproperty
  a_ol: assert property (p_ol) else $error("online in data");
  property p_st; tape_exception && !busy |->
    ##[1:40] (tape_request && bus_out == tape_pkg::CMD_READ_STATUS);
  endproperty
  a_st: assert property (p_st) else $error("no status read");
  c_wr: cover property (wr_ready);
  c_rd: cover property (rd_valid);
  c_st: cover property (status_valid);
endmodule
bind tape_host_handshake tape_host_handshake_monitor i_mon (
  .mclk, .rstn, .busy, .bus_oe, .bus_out, .tape_ready, .tape_ack,
  .tape_dir, .tape_exception, .tape_request, .tape_xfer, .tape_online,
  .wr_ready, .rd_valid, .status_valid
);
`default_nettype wire

// ---- test/tb.sv ----
// Self-checking bench for the tape host handshake
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic mclk, rstn, op_valid, wr_valid, wr_last, rd_stop, drive_reset_req;
  logic rd_mode, exc_go, op_ready, wr_ready, rd_valid, status_valid, busy;
  logic bus_oe, tape_ready, tape_exception, tape_ack, tape_dir;
  logic tape_request, tape_xfer, tape_online, tape_reset;
  logic [1:0] op_kind;
  logic [7:0] op_cmd, wr_data, rd_data, status_data, bus_in, bus_out;
  logic [7:0] cmd, wbyte, n_wr;
  int n_mismatch, checks_done;
  tape_host_handshake #(.RESET_CYC(4)) i_tape_host_handshake (
    .mclk, .rstn, .op_valid, .op_kind, .op_cmd, .op_ready, .wr_valid,
    .wr_data, .wr_last, .wr_ready, .rd_valid, .rd_data, .rd_stop,
    .drive_reset_req, .status_valid, .status_data, .busy, .bus_in,
    .bus_out, .bus_oe, .tape_ready, .tape_exception, .tape_ack, .tape_dir,
    .tape_request, .tape_xfer, .tape_online, .tape_reset);
  tape_drive_model i_tape_drive_model (
    .mclk, .rstn, .bus_out, .tape_request, .tape_xfer, .tape_reset,
    .bus_in, .tape_ready, .tape_exception, .tape_ack, .tape_dir,
    .rd_mode, .exc_go, .cmd, .wbyte, .n_wr);
  task finish_test;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  function logic sig(input int k);
    case (k)
      0: sig = op_ready;
      1: sig = wr_ready;
      2: sig = rd_valid;
      3: sig = status_valid;
      4: sig = tape_reset;
      default: sig = ~busy;
    endcase
  endfunction
  // Bounded wait on a handshake at the falling edge
  task wt(input int k);
    int i;
    @(negedge mclk);
    for (i = 0; i < 600 && sig(k) !== 1'b1; i++)
      @(negedge mclk);
    if (i == 600) begin
      n_mismatch++;
      finish_test();
    end
  endtask
  task op(input logic [1:0] k, input logic [7:0] c);
    op_kind = k;
    op_cmd = c;
    op_valid = 1'b1;
    wt(0);
    op_valid = 1'b0;
  endtask
  task t_cmd;
    op(tape_pkg::OP_CMD, 8'h2a);
    wt(5);
    chk("cmd", 8'h2a, cmd);
  endtask
  task t_reset;
    int n;
    drive_reset_req = 1'b1;
    wt(4);
    drive_reset_req = 1'b0;
    for (n = 0; tape_reset === 1'b1 && n < 100; n++)
      @(negedge mclk);
    if (n == 100) begin
      n_mismatch++;
      finish_test();
    end
    chk("reset cmd", 8'h00, cmd);
  endtask
  task t_write;
    int j;
    op(tape_pkg::OP_WRITE, 8'h40);
    wr_valid = 1'b1;
    for (j = 0; j < 3; j++) begin
      wr_data = 8'ha0 + 8'(j);
      wr_last = (j == 2);
      wt(1);
    end
    wr_valid = 1'b0;
    wr_last = 1'b0;
    wt(5);
    chk("wr byte", 8'ha2, wbyte);
    chk("wr count", 8'h03, n_wr);
    chk("online", 8'h00, {7'h00, tape_online});
  endtask
  // Exception with an op pending: status read goes first
  task t_status;
    exc_go = 1'b1;
    @(negedge mclk);
    exc_go = 1'b0;
    repeat (4) @(negedge mclk);
    op_kind = tape_pkg::OP_CMD;
    op_cmd = 8'h33;
    op_valid = 1'b1;
    wt(3);
    chk("status cmd", tape_pkg::CMD_READ_STATUS, cmd);
    chk("status", 8'h5a, status_data);
    wt(0);
    op_valid = 1'b0;
    wt(5);
    chk("held cmd", 8'h33, cmd);
    chk("online", 8'h01, {7'h00, tape_online});
  endtask
  task t_read;
    op(tape_pkg::OP_READ, 8'h80);
    rd_mode = 1'b1;
    wt(2);
    chk("rd byte", 8'h10, rd_data);
    wt(2);
    chk("rd byte", 8'h11, rd_data);
    rd_stop = 1'b1;
    wt(5);
    rd_stop = 1'b0;
    rd_mode = 1'b0;
  endtask
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  initial begin
    {rstn, op_valid, wr_valid, wr_last, rd_stop, drive_reset_req} = '0;
    {rd_mode, exc_go, op_kind, op_cmd, wr_data} = '0;
    n_mismatch = 0;
    checks_done = 0;
    repeat (16) @(negedge mclk);
    rstn = 1'b1;
    t_cmd();
    t_reset();
    t_write();
    t_status();
    t_read();
    t_status();
    finish_test();
  end
endmodule
`default_nettype wire
